// >>> hw/phr_page_bank.sv
// storage for the implemented pages of the paged register range
`timescale 1ns/100ps
module phr_page_bank #(
	parameter int SLOTS = 3,
	parameter int REGS = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// access
	input wire logic wr_en,
	input wire logic [2:0] page,
	input wire logic [2:0] index,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	import phr_pkg::*;

	// =========================================
	// page to slot map
	logic slot_ok;
	logic [1:0] slot;
	logic [7:0] mem [SLOTS*REGS];

	always_comb
	begin
		slot_ok = 1'b1;
		slot = 2'd0;
		if (page == PAGE_TOP)
			slot = 2'd2;
		else if (page >= PAGE_RSVD_LO && page <= PAGE_RSVD_HI)
			slot_ok = 1'b0;
		else
			slot = page[1:0];
	end

	// =========================================
	// entries
	genvar g;
	generate
		for (g = 0; g < SLOTS*REGS; g++)
		begin : gen_entry
			logic [7:0] ent_next;
			always_comb
			begin
				ent_next = mem[g];
				if (wr_en && slot_ok && (int'(slot) * REGS + int'(index)) == g)
					ent_next = wdata;
			end
			always_ff @(posedge mclk or posedge reset)
			begin
				if (reset)
					mem[g] <= 8'h00;
				else
					mem[g] <= ent_next;
			end
		end
	endgenerate

	// reserved pages never reach storage
	assign rdata = slot_ok ? mem[int'(slot) * REGS + int'(index)] : 8'h00; // R06
endmodule

// >>> hw/phr_pkg.sv
// shared constants of the paged register file
package phr_pkg;

	// =========================================
	// bus and address map
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam logic [3:0] IDX_NODE_ID_ROOT_POWER = 4'h0;
	localparam logic [3:0] IDX_HOLDOFF_RESET_GAP = 4'h1;
	localparam logic [3:0] IDX_EXTENSION_PORT_COUNT = 4'h2;
	localparam logic [3:0] IDX_SPEED_STANDBY_DELAY = 4'h3;
	localparam logic [3:0] IDX_LINK_CONTENDER_POWER = 4'h4;
	localparam logic [3:0] IDX_INTERRUPT_FEATURE_ENABLES = 4'h5;
	localparam logic [3:0] IDX_LEGACY_SPEED_BRIDGE = 4'h6;
	localparam logic [3:0] IDX_PAGE_PORT_SELECTOR = 4'h7;
	localparam logic [3:0] IDX_PAGED_FIRST = 4'h8;
	localparam int REG_COUNT = 16;

	// =========================================
	// field positions (bit 7 is the leftmost field)
	localparam int POS_NODE_ADDRESS = 2;
	localparam int POS_ROOT = 1;
	localparam int POS_CABLE_POWER = 0;
	localparam int POS_ROOT_HOLDOFF = 7;
	localparam int POS_LONG_RESET = 6;
	localparam int POS_GAP = 0;
	localparam int POS_EXTENDED = 5;
	localparam int POS_NUM_PORTS = 0;
	localparam int POS_LEGACY_SPEED = 5;
	localparam int POS_STANDBY_RESTORE = 4;
	localparam int POS_DELAY = 0;
	localparam int POS_LINK_ACTIVE = 7;
	localparam int POS_CONTENDER = 6;
	localparam int POS_JITTER = 3;
	localparam int POS_POWER_CLASS = 0;
	localparam int POS_WATCHDOG_IRQ_EN = 7;
	localparam int POS_SHORT_RESET = 6;
	localparam int POS_IRQ_FLAGS = 2;
	localparam int POS_ARB_ACCEL = 1;
	localparam int POS_MULTISPEED = 0;
	localparam int POS_MAX_LEGACY = 5;
	localparam int POS_BETA_LINK = 4;
	localparam int POS_BRIDGE = 2;
	localparam int POS_PAGE_SELECT = 5;
	localparam int POS_PORT_SELECT = 0;

	// =========================================
	// constant field values and reset values
	localparam logic [2:0] EXTENDED_VAL = 3'h7;
	localparam logic [3:0] NUM_PORTS_VAL = 4'h3;
	localparam logic [2:0] LEGACY_SPEED_VAL = 3'h7;
	localparam logic [3:0] DELAY_VAL = 4'hf;
	localparam logic [2:0] JITTER_VAL = 3'h0;
	localparam logic [5:0] GAP_RESET = 6'h3f;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam logic [3:0] PORT_RESET = 4'h0;
	localparam logic [2:0] POWER_CLASS_RESET = 3'h0;
	localparam logic [2:0] PAGE_RSVD_LO = 3'h2;
	localparam logic [2:0] PAGE_RSVD_HI = 3'h6;
	localparam logic [2:0] PAGE_TOP = 3'h7;

	// =========================================
	// timing
	localparam int REPEATER_BASE_NS = 144;
	localparam int REPEATER_STEP_NS = 20;
	localparam int CLK_PERIOD_NS = 50;
	localparam int LONG_RESET_US = 166;
	localparam int LONG_RESET_CYC = (LONG_RESET_US * 1000) / CLK_PERIOD_NS;

	// =========================================
	// long bus reset sequencer
	typedef enum logic [1:0] {
		PHR_ST_IDLE = 2'b01,
		PHR_ST_DRIVE = 2'b10
	} phr_lr_state_t;

endpackage

// >>> hw/phr_regfile.sv
// paged register file of the cable physical layer, apb slave
//
// Overview of operation
// [R01] Sixteen registers are addressed, and indices 0 to 7 form a base group with a fixed layout.
// [R02] Indices 8 to 15 reach a paged group whose contents follow the selected page 0 to 7.
// [R03] The page comes from the page-select field of register 7, which also holds port-select and a reserved bit.
// [R04] Base registers decode the same fields whichever page is selected.
// [R05] Reserved registers and reserved bit fields read as zero.
// [R06] All registers of pages 2 to 6 are reserved and read as zero.
// [R07] The gap count resets to 3fh on hardware reset and after two bus resets with no write in between.
// [R08] The long bus reset request starts a 166 us bus reset once no transfer is busy, and clears on any reset.
// [R09] Root holdoff clears on hardware reset and keeps its value across bus resets.
// [R10] The repeater delay field means 144 plus 20 times its value in nanoseconds.
// [R11] Page select and port select come out of hardware reset as zero.
`timescale 1ns/100ps
module phr_regfile #(
	parameter int LONG_RESET_CYCLES = phr_pkg::LONG_RESET_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [phr_pkg::APB_AW-1:0] paddr,
	input wire logic [phr_pkg::APB_DW-1:0] pwdata,
	output logic [phr_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// node status from the phy core
	input wire logic [5:0] node_address,
	input wire logic root_flag,
	input wire logic cable_power_status,
	input wire logic beta_link_flag,
	input wire logic transfer_busy,
	input wire logic bus_reset_event,
	input wire logic config_gap_valid,
	input wire logic [5:0] config_gap_value,
	input wire logic [3:0] irq_event,
	// controls to the phy core
	output logic [5:0] gap_count,
	output logic root_holdoff,
	output logic long_reset_active,
	output logic short_bus_reset_request,
	output logic standby_restore_en,
	output logic link_active_ctl,
	output logic contender,
	output logic [2:0] power_class,
	output logic watchdog_irq_en,
	output logic arb_accel_en,
	output logic multispeed_concat_en,
	output logic [2:0] page_select,
	output logic [3:0] port_select,
	output logic [9:0] repeater_delay_ns
);
	import phr_pkg::*;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// =========================================
	// apb decode
	logic mapped;
	logic [3:0] idx;
	logic wr_access;
	logic rd_setup;

	assign idx = paddr[5:2];
	// byte address is four times the index; upper and low bits must be zero
	assign mapped = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:6] == '0); // R01
	assign wr_access = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	logic wr_r1;
	logic wr_r3;
	logic wr_r4;
	logic wr_r5;
	logic wr_r6;
	logic wr_r7;
	assign wr_r1 = wr_access && idx == IDX_HOLDOFF_RESET_GAP;
	assign wr_r3 = wr_access && idx == IDX_SPEED_STANDBY_DELAY;
	assign wr_r4 = wr_access && idx == IDX_LINK_CONTENDER_POWER;
	assign wr_r5 = wr_access && idx == IDX_INTERRUPT_FEATURE_ENABLES;
	assign wr_r6 = wr_access && idx == IDX_LEGACY_SPEED_BRIDGE;
	assign wr_r7 = wr_access && idx == IDX_PAGE_PORT_SELECTOR;

	// =========================================
	// writable base fields
	logic [5:0] gap_reg, gap_next;
	logic gap_seen_reg, gap_seen_next;
	logic holdoff_reg, holdoff_next;
	logic lbr_reg, lbr_next;
	logic sbr_reg, sbr_next;
	logic [7:0] r3_reg, r3_next;
	logic [7:0] r4_reg, r4_next;
	logic [7:0] r5_reg, r5_next;
	logic [1:0] bridge_reg, bridge_next;
	logic [2:0] page_reg, page_next;
	logic [3:0] port_reg, port_next;
	logic lr_done;

	always_comb
	begin
		gap_next = gap_reg;
		gap_seen_next = gap_seen_reg;
		holdoff_next = holdoff_reg;
		lbr_next = lbr_reg;
		sbr_next = sbr_reg;
		r3_next = r3_reg;
		r4_next = r4_reg;
		r5_next = r5_reg;
		bridge_next = bridge_reg;
		page_next = page_reg;
		port_next = port_reg;
		// a write counts as intervening even in the same cycle as a bus reset
		if (wr_r1 || config_gap_valid)
		begin
			gap_next = wr_r1 ? pwdata[POS_GAP +: 6] : config_gap_value;
			gap_seen_next = 1'b0;
		end
		else if (bus_reset_event)
		begin
			if (gap_seen_reg)
				gap_next = GAP_RESET; // R07
			gap_seen_next = 1'b1;
		end
		if (bus_reset_event || lr_done)
		begin
			lbr_next = 1'b0; // R08
			sbr_next = 1'b0;
		end
		if (wr_r1)
		begin
			holdoff_next = pwdata[POS_ROOT_HOLDOFF]; // R09
			lbr_next = pwdata[POS_LONG_RESET];
		end
		if (wr_r3)
			r3_next[POS_STANDBY_RESTORE] = pwdata[POS_STANDBY_RESTORE];
		if (wr_r4)
		begin
			r4_next[POS_LINK_ACTIVE] = pwdata[POS_LINK_ACTIVE];
			r4_next[POS_CONTENDER] = pwdata[POS_CONTENDER];
			r4_next[POS_POWER_CLASS +: 3] = pwdata[POS_POWER_CLASS +: 3];
		end
		if (wr_r5)
		begin
			r5_next[POS_WATCHDOG_IRQ_EN] = pwdata[POS_WATCHDOG_IRQ_EN];
			r5_next[POS_ARB_ACCEL] = pwdata[POS_ARB_ACCEL];
			r5_next[POS_MULTISPEED] = pwdata[POS_MULTISPEED];
			sbr_next = pwdata[POS_SHORT_RESET];
		end
		// event flags: writing one clears, a new event in the same cycle wins
		for (int i = 0; i < 4; i++)
		begin
			if (wr_r5 && pwdata[POS_IRQ_FLAGS + i])
				r5_next[POS_IRQ_FLAGS + i] = 1'b0;
			if (irq_event[i])
				r5_next[POS_IRQ_FLAGS + i] = 1'b1;
		end
		if (wr_r6)
			bridge_next = pwdata[POS_BRIDGE +: 2];
		if (wr_r7)
		begin
			page_next = pwdata[POS_PAGE_SELECT +: 3]; // R03
			port_next = pwdata[POS_PORT_SELECT +: 4];
		end
		// only the storage bits of registers 3 to 5 are kept
		r3_next = r3_next & 8'h10;
		r4_next = r4_next & 8'hc7;
		r5_next = r5_next & 8'hbf;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			gap_reg <= GAP_RESET; // R07
			gap_seen_reg <= 1'b0;
			holdoff_reg <= 1'b0; // R09
			lbr_reg <= 1'b0;
			sbr_reg <= 1'b0;
			r3_reg <= 8'h00;
			r4_reg <= 8'h00;
			r5_reg <= 8'h00;
			bridge_reg <= 2'h0;
			page_reg <= PAGE_RESET; // R11
			port_reg <= PORT_RESET; // R11
		end
		else
		begin
			gap_reg <= gap_next;
			gap_seen_reg <= gap_seen_next;
			holdoff_reg <= holdoff_next;
			lbr_reg <= lbr_next;
			sbr_reg <= sbr_next;
			r3_reg <= r3_next;
			r4_reg <= r4_next;
			r5_reg <= r5_next;
			bridge_reg <= bridge_next;
			page_reg <= page_next;
			port_reg <= port_next;
		end
	end

	// =========================================
	// long bus reset sequencer
	phr_lr_state_t lr_state_reg, lr_state_next;
	logic [11:0] lr_cnt_reg, lr_cnt_next;

	always_comb
	begin
		lr_state_next = lr_state_reg;
		lr_cnt_next = lr_cnt_reg;
		lr_done = 1'b0;
		case (lr_state_reg)
			PHR_ST_IDLE:
			begin
				// a transfer in progress finishes first
				if (lbr_reg && !transfer_busy) // R08
				begin
					lr_state_next = PHR_ST_DRIVE;
					lr_cnt_next = 12'h001;
				end
			end
			PHR_ST_DRIVE:
			begin
				if (lr_cnt_reg == 12'(LONG_RESET_CYCLES)) // R08
				begin
					lr_state_next = PHR_ST_IDLE;
					lr_cnt_next = 12'h000;
					lr_done = 1'b1;
				end
				else
					lr_cnt_next = lr_cnt_reg + 12'h001;
			end
			default:
			begin
				lr_state_next = PHR_ST_IDLE;
				lr_cnt_next = 12'h000;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			lr_state_reg <= PHR_ST_IDLE;
			lr_cnt_reg <= 12'h000;
		end
		else
		begin
			lr_state_reg <= lr_state_next;
			lr_cnt_reg <= lr_cnt_next;
		end
	end

	// =========================================
	// read path
	logic [7:0] base_rd;
	logic [7:0] paged_rd;
	logic [APB_DW-1:0] prdata_reg, prdata_next;

	phr_page_bank #(
		.SLOTS(3),
		.REGS(8)
	) u_page_bank (
		.mclk(mclk),
		.reset(reset),
		.wr_en(wr_access && idx[3]), // R02
		.page(page_reg),
		.index(idx[2:0]),
		.wdata(pwdata[7:0]),
		.rdata(paged_rd)
	);

	// base decode ignores the page entirely; unused bits stay zero
	always_comb
	begin
		base_rd = 8'h00; // R05
		case (idx[2:0]) // R04
			3'h0: base_rd = {node_address, root_flag, cable_power_status};
			3'h1: base_rd = {holdoff_reg, lbr_reg, gap_reg};
			3'h2: base_rd = {EXTENDED_VAL, 1'b0, NUM_PORTS_VAL};
			3'h3: base_rd = r3_reg | {LEGACY_SPEED_VAL, 1'b0, DELAY_VAL}; // R10
			3'h4: base_rd = r4_reg | {2'b00, JITTER_VAL, 3'h0};
			3'h5: base_rd = r5_reg | {1'b0, sbr_reg, 6'h00};
			3'h6: base_rd = {LEGACY_SPEED_VAL, beta_link_flag, bridge_reg, 2'b00};
			3'h7: base_rd = {page_reg, 1'b0, port_reg}; // R03
			default: base_rd = 8'h00;
		endcase
	end

	// data captured in the setup phase, presented through the access phase
	always_comb
	begin
		prdata_next = prdata_reg;
		if (rd_setup)
		begin
			prdata_next = '0;
			if (mapped)
				prdata_next[7:0] = idx[3] ? paged_rd : base_rd; // R01
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			prdata_reg <= '0;
		else
			prdata_reg <= prdata_next;
	end

	// =========================================
	// outputs
	assign prdata = prdata_reg;
	assign gap_count = gap_reg;
	assign root_holdoff = holdoff_reg;
	assign long_reset_active = (lr_state_reg == PHR_ST_DRIVE);
	assign short_bus_reset_request = sbr_reg;
	assign standby_restore_en = r3_reg[POS_STANDBY_RESTORE];
	assign link_active_ctl = r4_reg[POS_LINK_ACTIVE];
	assign contender = r4_reg[POS_CONTENDER];
	assign power_class = r4_reg[POS_POWER_CLASS +: 3];
	assign watchdog_irq_en = r5_reg[POS_WATCHDOG_IRQ_EN];
	assign arb_accel_en = r5_reg[POS_ARB_ACCEL];
	assign multispeed_concat_en = r5_reg[POS_MULTISPEED];
	assign page_select = page_reg;
	assign port_select = port_reg;
	assign repeater_delay_ns = 10'(REPEATER_BASE_NS + REPEATER_STEP_NS * int'(DELAY_VAL)); // R10

	// =========================================
	// checks
	logic [11:0] act_cnt_reg;
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			act_cnt_reg <= 12'h000;
		else if (long_reset_active)
			act_cnt_reg <= act_cnt_reg + 12'h001;
		else
			act_cnt_reg <= 12'h000;
	end

	a_gap_after_reset: assert property (!reset && $past(reset) |-> gap_count == 6'h3f) // R07
		else $error("gap count not 3fh after reset");
	a_gap_two_resets: assert property (bus_reset_event && gap_seen_reg && !wr_r1 && !config_gap_valid
		|=> gap_count == 6'h3f) // R07
		else $error("gap count not restored after second bus reset");
	a_long_reset_len: assert property ($fell(long_reset_active) |-> act_cnt_reg == 12'(LONG_RESET_CYCLES)) // R08
		else $error("long bus reset has wrong length");
	a_long_reset_start: assert property ($rose(long_reset_active) |-> $past(lbr_reg) && !$past(transfer_busy)) // R08
		else $error("long bus reset started without request or during transfer");
	a_long_req_clear: assert property (bus_reset_event && !wr_r1 |=> !lbr_reg) // R08
		else $error("long reset request survived a bus reset");
	a_holdoff_kept: assert property (bus_reset_event && !wr_r1 |=> root_holdoff == $past(root_holdoff)) // R09
		else $error("root holdoff changed on bus reset");
	a_page_from_reg: assert property (wr_r7 |=> page_select == $past(pwdata[7:5]) ##1 page_select == $past(page_select)) // R03
		else $error("page select not taken from register 7");
	a_rsvd_page_zero: assert property (rd_setup && mapped && idx[3] && page_select inside {[3'h2:3'h6]}
		|=> prdata == 32'h0000_0000) // R06
		else $error("reserved page read nonzero");
	a_rsvd_bits_zero: assert property (rd_setup && mapped && idx == 4'h7
		|=> prdata[31:8] == 24'h000000 && prdata[4] == 1'b0 && prdata[7:5] == page_select) // R05
		else $error("reserved bits of register 7 read nonzero");
	a_base_page_free: assert property (rd_setup && mapped && idx == 4'h0
		|=> prdata[7:2] == $past(node_address) && prdata[0] == $past(cable_power_status)) // R04
		else $error("base register 0 decoded wrongly");
	a_delay_code: assert property (repeater_delay_ns == 10'd444) // R10
		else $error("repeater delay encoding wrong");
	a_select_reset: assert property (!reset && $past(reset) |-> page_select == 3'h0 && port_select == 4'h0) // R11
		else $error("page or port select not zero after reset");
endmodule

// >>> test/phr_link_model.sv
// apb master standing in for the link-layer controller
`timescale 1ns/100ps
module phr_link_model (
	// clock
	input wire logic mclk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [phr_pkg::APB_AW-1:0] paddr,
	output logic [phr_pkg::APB_DW-1:0] pwdata,
	input wire logic [phr_pkg::APB_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import phr_pkg::*;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// =========================================
	// one transfer, entered and left just after a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
	begin
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not look like the last request
		paddr <= ~a;
		pwdata <= ~wd;
		// idle edge so the next call never reassigns in this time step
		@(posedge mclk);
	end
	endtask
endmodule

// >>> test/tb_phr_regfile.sv
// self-checking bench of the paged register file
`timescale 1ns/100ps
module tb_phr_regfile;
	import phr_pkg::*;
	localparam int LR = 20;
	logic mclk;
	logic reset;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic busy;
	logic br;
	logic cgv;
	logic [5:0] cgval;
	logic [3:0] irq;
	logic [5:0] gap_count;
	logic root_holdoff;
	logic lra;
	logic sbr;
	logic [15:0] ctl;
	logic [9:0] rep_ns;
	logic [31:0] d;
	logic e;
	int fails;
	int cmp_count;
	int cycles;
	int n;
	logic [7:0] rst_exp [8] = '{8'hab, 8'h3f, 8'he3, 8'hef, 8'h00, 8'h00, 8'hf0, 8'h00};
	// index, write value, expected read
	logic [19:0] tbl [7] = '{20'h0ffab, 20'h200e3, 20'h3ffff, 20'h4ffc7, 20'h58383, 20'h6fffc, 20'h7bfaf};

	phr_link_model phr_link_model_inst (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	phr_regfile #(.LONG_RESET_CYCLES(LR)) phr_regfile_inst (.mclk(mclk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .node_address(6'h2a), .root_flag(1'b1), .cable_power_status(1'b1),
		.beta_link_flag(1'b1), .transfer_busy(busy), .bus_reset_event(br), .config_gap_valid(cgv),
		.config_gap_value(cgval), .irq_event(irq), .gap_count(gap_count), .root_holdoff(root_holdoff),
		.long_reset_active(lra), .short_bus_reset_request(sbr), .standby_restore_en(ctl[15]),
		.link_active_ctl(ctl[14]), .contender(ctl[13]), .power_class(ctl[12:10]), .watchdog_irq_en(ctl[9]),
		.arb_accel_en(ctl[8]), .multispeed_concat_en(ctl[7]), .page_select(ctl[2:0]), .port_select(ctl[6:3]),
		.repeater_delay_ns(rep_ns));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// =========================================
	// helpers
	task automatic give_verdict();
	begin
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] v);
	begin
		phr_link_model_inst.xfer(1'b1, {2'b00, idx, 2'b00}, {24'h0, v}, d, e);
	end
	endtask

	task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
	begin
		phr_link_model_inst.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, d, e);
		chk(d, {24'h0, exp});
		// a mapped access never raises the error line
		chk({31'h0, e}, 32'h0);
	end
	endtask

	task automatic pulse_br();
	begin
		br <= 1'b1;
		@(posedge mclk);
		br <= 1'b0;
		@(posedge mclk);
	end
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			give_verdict();
		end
	end

	// =========================================
	// main sequence
	initial
	begin
		reset = 1'b1;
		busy = 1'b0;
		br = 1'b0;
		cgv = 1'b0;
		cgval = 6'h00;
		irq = 4'h0;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 8; i++)
			rdc(4'(i), rst_exp[i]);
		chk({26'h0, gap_count}, {26'h0, GAP_RESET});
		chk({22'h0, rep_ns}, 32'(REPEATER_BASE_NS + REPEATER_STEP_NS * DELAY_VAL));
		for (int i = 0; i < 7; i++)
		begin
			wr(tbl[i][19:16], tbl[i][15:8]);
			rdc(tbl[i][19:16], tbl[i][7:0]);
		end
		chk({16'h0, ctl}, 32'h0000fffd);
		// event flags: set by pulses, cleared only where a one is written
		irq <= 4'h5;
		@(posedge mclk);
		irq <= 4'h0;
		@(posedge mclk);
		rdc(4'h5, 8'h97);
		wr(4'h5, 8'h87);
		rdc(4'h5, 8'h93);
		// short reset request stands until the next bus reset
		wr(4'h5, 8'h40);
		rdc(4'h5, 8'h50);
		chk({31'h0, sbr}, 32'h1);
		pulse_br();
		rdc(4'h5, 8'h10);
		chk({31'h0, sbr}, 32'h0);
		for (int p = 0; p < 8; p++)
		begin
			wr(4'h7, {3'(p), 5'h00});
			wr(4'(8 + p), 8'(8'h50 + p));
			rdc(4'(8 + p), (p < 2 || p == 7) ? 8'(8'h50 + p) : 8'h00);
			rdc(4'h1, 8'h3f);
			rdc(4'h2, 8'he3);
		end
		wr(4'h7, 8'h00);
		rdc(4'h8, 8'h50);
		wr(4'h7, 8'h20);
		rdc(4'h9, 8'h51);
		// unmapped and misaligned addresses
		phr_link_model_inst.xfer(1'b0, 8'h40, 32'h0, d, e);
		chk(d, 32'h0);
		chk({31'h0, e}, 32'h1);
		phr_link_model_inst.xfer(1'b1, 8'h45, 32'hff, d, e);
		chk({31'h0, e}, 32'h1);
		rdc(4'h1, 8'h3f);
		wr(4'h1, 8'h10);
		pulse_br();
		rdc(4'h1, 8'h10);
		pulse_br();
		rdc(4'h1, 8'h3f);
		wr(4'h1, 8'h90);
		pulse_br();
		cgv <= 1'b1;
		cgval <= 6'h12;
		@(posedge mclk);
		cgv <= 1'b0;
		@(posedge mclk);
		pulse_br();
		rdc(4'h1, 8'h92);
		chk({25'h0, root_holdoff, gap_count}, 32'h00000052);
		busy <= 1'b1;
		wr(4'h1, 8'hd2);
		pulse_br();
		rdc(4'h1, 8'h92);
		wr(4'h1, 8'hd2);
		repeat (10) @(posedge mclk);
		chk({31'h0, lra}, 32'h0);
		rdc(4'h1, 8'hd2);
		busy <= 1'b0;
		for (int i = 0; i < 10 && lra !== 1'b1; i++)
			@(posedge mclk);
		n = 0;
		while (lra === 1'b1 && n < 200)
		begin
			n++;
			@(posedge mclk);
		end
		chk(32'(n), 32'(LR));
		rdc(4'h1, 8'h92);
		// hardware reset in mid-run with a long reset request pending
		busy <= 1'b1;
		wr(4'h1, 8'hd2);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		busy <= 1'b0;
		@(posedge mclk);
		rdc(4'h1, 8'h3f);
		rdc(4'h7, 8'h00);
		rdc(4'h8, 8'h00);
		chk({31'h0, lra}, 32'h0);
		give_verdict();
	end
endmodule
